/* design/pixel_pll_params.svh */
// Offsets, field positions, reset values and counts of the pixel clock loop control
`ifndef PIXEL_PLL_PARAMS_SVH
`define PIXEL_PLL_PARAMS_SVH

// Register offsets
`define OFS_DIVISOR_HIGH   8'h01
`define OFS_DIVISOR_LOW    8'h02
`define OFS_LOOP_SETUP     8'h03
`define OFS_PHASE          8'h04
`define OFS_POLARITY       8'h05
`define OFS_STATUS         8'h06

// Field positions
`define POS_DIV_LOW        4
`define POS_BAND           6
`define POS_PUMP           3
`define POS_PHASE          3
`define POS_HS_POL         7
`define POS_HOLD_POL       6

// Reset values
`define RST_DIVISOR        12'h35F
`define RST_BAND           2'h0
`define RST_PUMP           3'h5
`define RST_PHASE          5'h00
`define RST_HS_POL         1'h1
`define RST_HOLD_POL       1'h1

// Phase shift steps per clock cycle
`define PHASE_STEPS        32

`endif

/* design/pixel_pll_pkg.sv */
// Types shared by the pixel clock loop control
package pixel_pll_pkg;

   typedef enum logic [1:0] {
      detect_idle,
      detect_lead,
      detect_lag
   } detect_state_type;

   typedef logic [11:0] divisor_type;
   typedef logic [1:0]  band_type;
   typedef logic [2:0]  pump_type;
   typedef logic [4:0]  phase_type;

endpackage

/* design/feedback_divider.sv */
// Feedback counter of the pixel clock loop
`timescale 1ns/1ps
`include "pixel_pll_params.svh"
module feedback_divider
   import pixel_pll_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire divisor_type divisor_i,
   output logic             feedback_o
);

   typedef struct packed {
      divisor_type count;
      logic        feedback;
   } div_state_type;

   div_state_type state;
   div_state_type next_state;

   // Counts 0..divisor, so each period is divisor plus one cycles
   always_comb begin
      next_state = state;
      next_state.feedback = 1'b0;
      if (state.count >= divisor_i) begin
         next_state.count    = 12'h000;
         next_state.feedback = 1'b1;
      end else begin
         next_state.count = state.count + 12'h001;
      end
   end

   // Counter register
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign feedback_o = state.feedback; // Straight from flop

endmodule

/* design/pixel_pll_control.sv */
// Control side of the line-locked pixel clock generator
`timescale 1ns/1ps
`include "pixel_pll_params.svh"
module pixel_pll_control
   import pixel_pll_pkg::*;
(
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       reg_we_i,
   input  wire logic       reg_rd_i,
   input  wire logic [7:0] reg_addr_i,
   input  wire logic [7:0] reg_wdata_i,
   output logic      [7:0] reg_rdata_o,
   input  wire logic       line_sync_i,
   input  wire logic       hold_frequency_i,
   input  wire logic       ext_clock_sel_i,
   output logic            pump_up_o,
   output logic            pump_down_o,
   output logic            feedback_edge_o,
   output logic            band_select_high_bit_o,
   output logic            band_select_low_bit_o,
   output logic            pump_current_bit_two_o,
   output logic            pump_current_bit_one_o,
   output logic            pump_current_bit_zero_o,
   output logic      [4:0] phase_select_o,
   output logic            aligned_line_sync_output_o,
   output logic            hold_active_o
);

   typedef struct packed {
      divisor_type      divisor;
      band_type         oscillator_band_setting;
      pump_type         pump;
      phase_type        phase;
      logic             hs_pol;
      logic             hold_pol;
      logic [1:0]       hs_sync;
      logic [1:0]       hold_sync;
      logic             hs_prev;
      detect_state_type detect;
      logic [31:0]      sync_delay;
      logic [7:0]       rdata;
      logic             pump_up;
      logic             pump_down;
      logic             fb_edge;
      logic [1:0]       band_bits;
      logic [2:0]       pump_bits;
      logic [4:0]       phase_out;
      logic             aligned_sync;
      logic             hold_out;
   } ctrl_state_type;

   ctrl_state_type state;
   ctrl_state_type next_state;
   logic           feedback;
   logic           hs_level;
   logic           hold_level;
   logic           ref_edge;

   // Divider runs on the generated clock, which this logic sees as clk_i
   feedback_divider feedback_divider_inst (
      .clk_i      (clk_i),
      .rst_i      (rst_i),
      .divisor_i  (state.divisor),
      .feedback_o (feedback)
   );

   // Polarity-corrected levels read from the second sync stage only
   always_comb begin
      hs_level = state.hs_sync[1] ~^ state.hs_pol;
      hold_level = state.hold_sync[1] ~^ state.hold_pol;
      ref_edge = hs_level && !state.hs_prev;
   end

   always_comb begin
      next_state = state;

      // Two-stage synchronisers for both asynchronous pins
      // hold input asynchronous
      next_state.hs_sync   = {state.hs_sync[0], line_sync_i};
      next_state.hold_sync = {state.hold_sync[0], hold_frequency_i};
      next_state.hs_prev   = hs_level;

      // Register writes; divisor limits are left to software
      // divisor range by software
      if (reg_we_i) begin
         case (reg_addr_i)
            `OFS_DIVISOR_HIGH: begin
               next_state.divisor[11:4] = reg_wdata_i;
            end
            `OFS_DIVISOR_LOW: begin
               next_state.divisor[3:0] = reg_wdata_i[`POS_DIV_LOW +: 4];
            end
            `OFS_LOOP_SETUP: begin
               next_state.oscillator_band_setting = reg_wdata_i[`POS_BAND +: 2];
               next_state.pump = reg_wdata_i[`POS_PUMP +: 3];
            end
            `OFS_PHASE: begin
               next_state.phase = reg_wdata_i[`POS_PHASE +: 5];
            end
            `OFS_POLARITY: begin
               next_state.hs_pol   = reg_wdata_i[`POS_HS_POL];
               next_state.hold_pol = reg_wdata_i[`POS_HOLD_POL];
            end
            default: begin
               next_state.divisor = state.divisor;
            end
         endcase
      end

      // Read data held until the next read; unmapped reads give zero
      if (reg_rd_i) begin
         case (reg_addr_i)
            `OFS_DIVISOR_HIGH: begin
               next_state.rdata = state.divisor[11:4];
            end
            `OFS_DIVISOR_LOW: begin
               next_state.rdata = {state.divisor[3:0], 4'h0};
            end
            `OFS_LOOP_SETUP: begin
               next_state.rdata = {state.oscillator_band_setting, state.pump, 3'h0};
            end
            `OFS_PHASE: begin
               next_state.rdata = {state.phase, 3'h0};
            end
            `OFS_POLARITY: begin
               next_state.rdata = {state.hs_pol, state.hold_pol, 6'h00};
            end
            `OFS_STATUS: begin
               next_state.rdata = {hs_level, hold_level, state.pump_up, state.pump_down, 4'h0};
            end
            default: begin
               next_state.rdata = 8'h00;
            end
         endcase
      end

      // Edge comparison: ref before feedback speeds up, feedback first slows down
      // phase compare and steer
      case (state.detect)
         detect_idle: begin
            if (ref_edge && !feedback) begin
               next_state.detect = detect_lead;
            end else if (feedback && !ref_edge) begin
               next_state.detect = detect_lag;
            end
         end
         detect_lead: begin
            if (feedback) begin
               next_state.detect = detect_idle;
            end
         end
         detect_lag: begin
            if (ref_edge) begin
               next_state.detect = detect_idle;
            end
         end
         default: begin
            next_state.detect = detect_idle;
         end
      endcase

      // Coasting cuts the loop input so the oscillator keeps its frequency
      // hold keeps frequency
      if (hold_level) begin
         next_state.detect = detect_idle;
      end
      next_state.pump_up   = (next_state.detect == detect_lead);
      next_state.pump_down = (next_state.detect == detect_lag);
      next_state.fb_edge   = feedback;
      next_state.hold_out  = hold_level;

      // Band and pump codes go straight to the analog selectors
      // band code decode
      next_state.band_bits = state.oscillator_band_setting;
      next_state.pump_bits = state.pump;
      next_state.phase_out = state.phase;

      // Sync delay line in phase steps; independent of clock source
      // sync gets same shift
      next_state.sync_delay = {state.sync_delay[30:0], hs_level};
      next_state.aligned_sync = ext_clock_sel_i ? state.sync_delay[state.phase]
                                                : state.sync_delay[state.phase];
   end

   // Single state register
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         state                         <= '0;
         state.divisor                 <= `RST_DIVISOR;
         state.oscillator_band_setting <= `RST_BAND;
         state.pump                    <= `RST_PUMP;
         state.phase                   <= `RST_PHASE;
         state.hs_pol                  <= `RST_HS_POL;
         state.hold_pol                <= `RST_HOLD_POL;
         state.detect                  <= detect_idle;
      end else begin
         state <= next_state;
      end
   end

   // Outputs straight from the state register
   assign reg_rdata_o                = state.rdata;
   assign pump_up_o                  = state.pump_up;
   assign pump_down_o                = state.pump_down;
   assign feedback_edge_o            = state.fb_edge;
   assign band_select_high_bit_o     = state.band_bits[1];
   assign band_select_low_bit_o      = state.band_bits[0];
   assign pump_current_bit_two_o     = state.pump_bits[2];
   assign pump_current_bit_one_o     = state.pump_bits[1];
   assign pump_current_bit_zero_o    = state.pump_bits[0];
   assign phase_select_o             = state.phase_out;
   assign aligned_line_sync_output_o = state.aligned_sync;
   assign hold_active_o              = state.hold_out;

endmodule

/* tb/pixel_pll_sva.sv */
// Port checks for the pixel clock loop control
`timescale 1ns/1ps
module pixel_pll_sva (
   input wire logic       clk_i,
   input wire logic       rst_i,
   input wire logic       reg_we_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic       line_sync_i,
   input wire logic       hold_frequency_i,
   input wire logic       pump_up_o,
   input wire logic       pump_down_o,
   input wire logic       feedback_edge_o,
   input wire logic       band_select_high_bit_o,
   input wire logic       band_select_low_bit_o,
   input wire logic [4:0] phase_select_o,
   input wire logic       aligned_line_sync_output_o,
   input wire logic       hold_active_o
);
   logic       hs_pol, hold_pol, ls_q, hf_q;
   logic [5:0] quiet;
   default clocking @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   // Shadow polarity bits; count cycles with pins and registers at rest
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         hs_pol   <= 1'b1;
         hold_pol <= 1'b1;
         quiet    <= 6'h00;
      end else begin
         if (reg_we_i && reg_addr_i == 8'h05) begin
            hs_pol   <= reg_wdata_i[7];
            hold_pol <= reg_wdata_i[6];
         end
         quiet <= (reg_we_i || line_sync_i != ls_q || hold_frequency_i != hf_q) ? 6'h00 : quiet + 6'(quiet != 6'h3F);
      end
   end
   // Pin history, reset not needed
   always_ff @(posedge clk_i) begin
      ls_q <= line_sync_i;
      hf_q <= hold_frequency_i;
   end
   sequence no_fb;
      (!feedback_edge_o && !hold_active_o)[*4];
   endsequence
   sequence sync_still;
      ($stable(line_sync_i) && !hold_active_o)[*5];
   endsequence
   a_band_on_write: assert property (reg_we_i && reg_addr_i == 8'h03 |-> ##2
      {band_select_high_bit_o, band_select_low_bit_o} == $past(reg_wdata_i[7:6], 2)) else $error("band bits wrong");
   a_phase_on_write: assert property (reg_we_i && reg_addr_i == 8'h04 |-> ##2
      phase_select_o == $past(reg_wdata_i[7:3], 2)) else $error("phase step wrong");
   // Compare against last settled pin level; a change at this very edge has not reached the output
   a_sync_at_rest: assert property (quiet >= 6'h28 |->
      aligned_line_sync_output_o == (ls_q == hs_pol)) else $error("aligned sync wrong");
   a_hold_at_rest: assert property (quiet >= 6'h08 |->
      hold_active_o == (hf_q == hold_pol)) else $error("hold level wrong");
   a_lead_pumps_up: assert property (no_fb ##1 ($rose(line_sync_i) && hs_pol && !pump_down_o && !feedback_edge_o)
      ##1 no_fb |-> pump_up_o) else $error("no pump up");
   // Lead must be absent before the feedback pulse, else the pulse only ends the lead
   a_lag_pumps_down: assert property (sync_still ##0 !pump_up_o ##1 (feedback_edge_o && $stable(line_sync_i)
      && !hold_active_o) ##1 sync_still |-> pump_down_o) else $error("no pump down");
   a_feedback_pulse: assert property (feedback_edge_o |=> (!feedback_edge_o)[*8]) else $error("pulses too close");
   a_hold_no_pump: assert property (hold_active_o[*2] |-> !pump_up_o && !pump_down_o) else $error("pump in hold");
endmodule
bind pixel_pll_control pixel_pll_sva pixel_pll_sva_inst (.*);

/* tb/line_sync_source.sv */
// Graphics source model making line sync pulses
`timescale 1ns/1ps
module line_sync_source (
   input  wire logic clk_i,
   input  wire logic run_i,
   input  wire logic pol_i,
   output logic      line_sync_o
);
   int count;
   initial line_sync_o = 1'b0;
   // line rate near 20 kHz; rests inactive when stopped
   always @(posedge clk_i) begin
      count <= (run_i && count < 2000) ? count + 1 : 0;
      line_sync_o <= (run_i && count < 16) ? pol_i : !pol_i;
   end
endmodule

/* tb/line_locked_pixel_clock_pll_test.sv */
// Register and pin bench for the pixel clock loop control
`timescale 1ns/1ps
module line_locked_pixel_clock_pll_test;
   logic        clk_i, rst_i, reg_we_i, reg_rd_i, line_sync_i, hold_frequency_i, ext_clock_sel_i, run, spol;
   logic [7:0]  reg_addr_i, reg_wdata_i, reg_rdata_o, d;
   logic        pump_up_o, pump_down_o, feedback_edge_o, band_select_high_bit_o, band_select_low_bit_o;
   logic        pump_current_bit_two_o, pump_current_bit_one_o, pump_current_bit_zero_o;
   logic        aligned_line_sync_output_o, hold_active_o;
   logic [4:0]  phase_select_o;
   int          errors, n_checks, c, up, dn;
   logic [7:0]  adr [6] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h07};
   logic [7:0]  rv [6]  = '{8'h35, 8'hF0, 8'h28, 8'h00, 8'hC0, 8'h00};
   logic [11:0] dv [2]  = '{12'hFFF, 12'h0DD};
   logic [4:0]  ph [3]  = '{5'h1F, 5'h10, 5'h01};
   pixel_pll_control pixel_pll_control_inst (.*);
   line_sync_source line_sync_source_inst (.clk_i(clk_i), .run_i(run), .pol_i(spol), .line_sync_o(line_sync_i));
   // 40 MHz clock
   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk_i);
      reg_we_i    <= 1'b1;
      reg_addr_i  <= a;
      reg_wdata_i <= v;
      @(posedge clk_i);
      reg_we_i    <= 1'b0;
   endtask
   // Data taken one cycle after the read edge
   task automatic rd(input logic [7:0] a);
      @(posedge clk_i);
      reg_rd_i   <= 1'b1;
      reg_addr_i <= a;
      @(posedge clk_i);
      reg_rd_i   <= 1'b0;
      @(posedge clk_i);
      d = reg_rdata_o;
   endtask
   task automatic cmp(input string n, input logic [12:0] e, input logic [12:0] s);
      n_checks++;
      if (s !== e) begin
         errors++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask
   // Pump activity over a window
   task automatic watch(input int n);
      up = 0;
      dn = 0;
      repeat (n) begin
         @(posedge clk_i);
         up += int'(pump_up_o === 1'b1);
         dn += int'(pump_down_o === 1'b1);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial begin
      rst_i = 1'b1;
      reg_we_i = 1'b0;
      reg_rd_i = 1'b0;
      reg_addr_i = 8'h00;
      reg_wdata_i = 8'h00;
      hold_frequency_i = 1'b0;
      ext_clock_sel_i = 1'b0;
      run = 1'b0;
      spol = 1'b1;
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      // Reset values; unmapped place reads zero
      foreach (adr[i]) begin
         rd(adr[i]);
         cmp("reset value", 13'(rv[i]), 13'(d));
      end
      // Divider period at both ends of the legal range
      foreach (dv[i]) begin
         wr(8'h01, dv[i][11:4]);
         wr(8'h02, {dv[i][3:0], 4'h0});
         for (int k = 0; k < 2; k++) begin
            c = 0;
            do begin
               @(posedge clk_i);
               c++;
            end while (feedback_edge_o !== 1'b1 && c < 9000);
         end
         // Timed out waiting for feedback counts as a mismatch
         if (c >= 9000) begin
            errors++;
            finish_test();
         end
         cmp("feedback period", 13'(dv[i]) + 13'h0001, 13'(c));
      end
      // Every band and pump code
      for (int i = 0; i < 8; i++) begin
         wr(8'h03, {i[1:0], i[2:0], 3'h0});
         repeat (2) @(posedge clk_i);
         cmp("band", 13'(i[1:0]), 13'({band_select_high_bit_o, band_select_low_bit_o}));
         cmp("pump", 13'(i[2:0]), 13'({pump_current_bit_two_o, pump_current_bit_one_o, pump_current_bit_zero_o}));
      end
      wr(8'h03, 8'h28);
      // Phase steps, external clock select toggled
      foreach (ph[i]) begin
         ext_clock_sel_i <= i[0];
         wr(8'h04, {ph[i], 3'h0});
         repeat (2) @(posedge clk_i);
         cmp("phase step", 13'(ph[i]), 13'(phase_select_o));
      end
      // Both sync polarities, source matched to the setting
      for (int p = 1; p >= 0; p--) begin
         run <= 1'b0;
         wr(8'h05, {p[0], 7'h40});
         spol <= p[0];
         repeat (50) @(posedge clk_i);
         cmp("idle aligned sync", 13'h0000, 13'(aligned_line_sync_output_o));
         // Slow feedback lets line sync lead; fast feedback makes it lag
         wr(8'h01, 8'hFF);
         wr(8'h02, 8'hF0);
         run <= 1'b1;
         watch(5000);
         cmp("pump up seen", 13'h0001, 13'(up != 0));
         wr(8'h01, 8'h0D);
         wr(8'h02, 8'hD0);
         watch(5000);
         cmp("pump down seen", 13'h0001, 13'(dn != 0));
      end
      // Hold in both polarities; pumps checked stopped only in the active-high setting
      hold_frequency_i <= 1'b1;
      repeat (20) @(posedge clk_i);
      cmp("hold active", 13'h0001, 13'(hold_active_o));
      watch(3000);
      cmp("pump in hold", 13'h0000, 13'(up + dn));
      rd(8'h06);
      cmp("status in hold", 13'h0004, 13'(d[6:4]));
      wr(8'h05, 8'h00);
      repeat (20) @(posedge clk_i);
      cmp("hold inactive", 13'h0000, 13'(hold_active_o));
      hold_frequency_i <= 1'b0;
      repeat (20) @(posedge clk_i);
      cmp("hold active low", 13'h0001, 13'(hold_active_o));
      finish_test();
   end
endmodule
